//--- rtl/dcf_regs.vh
// Constants for the dual-clock 64x9 FIFO: geometry, flag levels, register map, reset values
`ifndef DCF_REGS_VH
`define DCF_REGS_VH

// Geometry
`define DCF_DEPTH          64
`define DCF_ADDR_W         6
`define DCF_WIDTH          9
`define DCF_CNT_W          7

// Fill levels that steer the flags (count width)
`define DCF_FULL_CNT       7'h40
`define DCF_NEAR_LO        7'h08
`define DCF_NEAR_HI        7'h38
`define DCF_HALF           7'h20

// Register byte offsets on APB
`define DCF_OFF_CTRL       12'h000
`define DCF_OFF_STATUS     12'h004
`define DCF_OFF_CLEAR      12'h008
`define DCF_OFF_HEAD       12'h00C

// Control register fields and reset value
`define DCF_CTRL_OE_BIT    0
`define DCF_CTRL_FLUSH_BIT 1
`define DCF_CTRL_RESET     1'b1

// Status register fields
`define DCF_ST_CNT_LSB     0
`define DCF_ST_FULL_N_BIT  8
`define DCF_ST_EMPTY_N_BIT 9
`define DCF_ST_NEAR_BIT    10
`define DCF_ST_HALF_BIT    11
`define DCF_ST_LDROP_BIT   12
`define DCF_ST_UDROP_BIT   13

// Clear register fields (write one to clear)
`define DCF_CLR_LDROP_BIT  0
`define DCF_CLR_UDROP_BIT  1

`endif

//--- rtl/dcf_strobe_sync.v
// Two-flop synchroniser with rising-edge detector for one strobe clock pin
module dcf_strobe_sync (
  input  wire pclk,
  input  wire presetn,
  input  wire strobe_in,
  output wire strobe_rise
);

  reg meta_q;
  reg sync_q;
  reg last_q;

  // First stage feeds only the second; edge logic looks at the later stages
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      meta_q <= 1'b0;
      sync_q <= 1'b0;
      last_q <= 1'b0;
    end
    else
    begin
      meta_q <= strobe_in;
      sync_q <= meta_q;
      last_q <= sync_q;
    end
  end

  // One-cycle pulse per low-to-high transition of the pin
  assign strobe_rise = sync_q & ~last_q;

endmodule // dcf_strobe_sync

//--- rtl/dcf_apb_regs.v
// APB slave holding the control, status, clear and head-word registers
`include "dcf_regs.vh"

module dcf_apb_regs (
  input  wire        pclk,
  input  wire        presetn,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  output wire [31:0] prdata,
  output wire        pready,
  output wire        pslverr,
  input  wire [31:0] status_word,
  input  wire [31:0] head_word,
  output wire        drive_en,
  output wire        flush_pulse,
  output wire [1:0]  clr_sticky
);

  reg  [31:0] rdata_q;
  reg         err_q;
  reg         oe_q;
  reg         flush_q;
  reg  [1:0]  clr_q;
  wire        setup_ph;
  wire        access_ph;
  wire        hit;
  wire        wr_ok;

  assign setup_ph  = psel & ~penable;
  assign access_ph = psel & penable;
  assign hit       = (paddr == `DCF_OFF_CTRL) | (paddr == `DCF_OFF_STATUS) |
                     (paddr == `DCF_OFF_CLEAR) | (paddr == `DCF_OFF_HEAD);
  assign wr_ok     = access_ph & pwrite & ~err_q;

  // Read data and error are latched in setup so no wait state is needed
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      rdata_q <= 32'h00000000;
      err_q   <= 1'b0;
    end
    else if (setup_ph)
    begin
      err_q <= ~hit;
      case (paddr)
        `DCF_OFF_CTRL:   rdata_q <= {31'h00000000, oe_q};
        `DCF_OFF_STATUS: rdata_q <= status_word;
        `DCF_OFF_HEAD:   rdata_q <= head_word;
        default:         rdata_q <= 32'h00000000;
      endcase
    end
  end

  // Writes land only on the access edge; flush and clears are one-cycle pulses
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      oe_q    <= `DCF_CTRL_RESET;
      flush_q <= 1'b0;
      clr_q   <= 2'h0;
    end
    else
    begin
      flush_q <= 1'b0;
      clr_q   <= 2'h0;
      if (wr_ok && paddr == `DCF_OFF_CTRL)
      begin
        oe_q    <= pwdata[`DCF_CTRL_OE_BIT];
        flush_q <= pwdata[`DCF_CTRL_FLUSH_BIT];
      end
      if (wr_ok && paddr == `DCF_OFF_CLEAR)
        clr_q <= {pwdata[`DCF_CLR_UDROP_BIT], pwdata[`DCF_CLR_LDROP_BIT]};
    end
  end

  assign prdata      = rdata_q;
  assign pready      = 1'b1;
  assign pslverr     = access_ph & err_q;
  assign drive_en    = oe_q;
  assign flush_pulse = flush_q;
  assign clr_sticky  = clr_q;

endmodule // dcf_apb_regs

//--- rtl/dcf_fifo_top.v
// Dual-strobe 64x9 FIFO: sampled strobes, flop storage, fill flags and APB access
//
// The address map and the APB register port are this design's own decisions.
`include "dcf_regs.vh"

// Timing: a strobe pin level is first caught by the metastability flop,
// the edge pulse follows one pclk edge later, and the count, flags and
// data outputs move on the next edge. A 40 MHz strobe spans five pclk
// periods, so every pin level is seen at least twice and no edge is lost.
// Limitation: the pins are sampled, not used as clocks, so the block's
// response trails each strobe edge by about three pclk cycles.

module dcf_fifo_top #(
  parameter WIDTH  = `DCF_WIDTH,
  parameter ADDR_W = `DCF_ADDR_W,
  parameter CNT_W  = `DCF_CNT_W
) (
  input  wire              pclk,
  input  wire              presetn,
  input  wire              psel,
  input  wire              penable,
  input  wire              pwrite,
  input  wire [11:0]       paddr,
  input  wire [31:0]       pwdata,
  output wire [31:0]       prdata,
  output wire              pready,
  output wire              pslverr,
  input  wire              load_strobe_clk,
  input  wire              unload_strobe_clk,
  input  wire [WIDTH-1:0]  data_in,
  output wire [WIDTH-1:0]  q_out,
  output wire              q_oe,
  output wire              full_flag_n,
  output wire              empty_flag_n,
  output wire              near_limit_flag,
  output wire              half_level_flag,
  output wire [CNT_W-1:0]  stored_word_count
);

  // Depth follows the pointer width so wrap-around needs no compare
  localparam DEPTH = 1 << ADDR_W;

  // Storage and pointers
  reg  [WIDTH-1:0]  mem [0:DEPTH-1];
  reg  [ADDR_W-1:0] wr_ptr_q;
  reg  [ADDR_W-1:0] wr_ptr_d;
  reg  [ADDR_W-1:0] rd_ptr_q;
  reg  [ADDR_W-1:0] rd_ptr_d;
  reg  [CNT_W-1:0]  count_q;
  reg  [CNT_W-1:0]  count_d;

  // Head word register and flags
  reg  [WIDTH-1:0]  head_q;
  reg  [WIDTH-1:0]  head_d;
  reg               full_n_q;
  reg               empty_n_q;
  reg               near_q;
  reg               half_q;
  reg               ldrop_q;
  reg               udrop_q;

  // Data input synchroniser stages
  reg  [WIDTH-1:0]  din_meta_q;
  reg  [WIDTH-1:0]  din_sync_q;

  // Strobe events, accepted events and register-side controls
  wire              load_rise;
  wire              unload_rise;
  wire              is_full;
  wire              is_empty;
  wire              do_wr;
  wire              do_rd;
  wire              drop_ld;
  wire              drop_ud;
  wire              drive_en;
  wire              flush;
  wire [1:0]        clr_sticky;
  reg  [31:0]       status_word;
  wire [31:0]       head_word;

  // Strobe pins come from another clock; each passes two flops before use
  // Each detector resets to the idle low pin level, so reset makes no edge
  dcf_strobe_sync u_load_sync (
    .pclk        (pclk),
    .presetn     (presetn),
    .strobe_in   (load_strobe_clk),
    .strobe_rise (load_rise)
  );

  dcf_strobe_sync u_unload_sync (
    .pclk        (pclk),
    .presetn     (presetn),
    .strobe_in   (unload_strobe_clk),
    .strobe_rise (unload_rise)
  );

  // Data bus is synchronised with the same depth as the strobe, so the word
  // taken on a detected edge was sampled together with that edge. The writer
  // must hold data for two pclk cycles past its strobe edge.
  // Bits may settle in different cycles; the hold window covers that skew.
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      din_meta_q <= {WIDTH{1'b0}};
      din_sync_q <= {WIDTH{1'b0}};
    end
    else
    begin
      din_meta_q <= data_in;
      din_sync_q <= din_meta_q;
    end
  end

  // Both strobes are seen in one domain, so one count replaces two pointer
  // crossings and full or empty can never be reported falsely
  // The trade: strobe rate is bounded by pclk, which 40 MHz comfortably meets
  assign is_full  = (count_q == `DCF_FULL_CNT);
  assign is_empty = (count_q == {CNT_W{1'b0}});

  // Accepted events; a flush overrides a strobe landing in the same cycle
  // Full and empty are judged on the count before the cycle's events, so a
  // load that meets a freeing unload while full is still dropped
  assign do_wr   = load_rise & ~is_full & ~flush;
  assign do_rd   = unload_rise & ~is_empty & ~flush;
  assign drop_ld = load_rise & is_full;
  assign drop_ud = unload_rise & is_empty;

  // Next pointers and count; the depth is a power of two so pointers wrap
  // A load and an unload both accepted in one cycle leave the count unchanged
  // Flush clears both pointers and the count at once and discards any strobe in that cycle
  always @*
  begin
    wr_ptr_d = wr_ptr_q;
    rd_ptr_d = rd_ptr_q;
    count_d  = count_q;
    if (flush)
    begin
      wr_ptr_d = {ADDR_W{1'b0}};
      rd_ptr_d = {ADDR_W{1'b0}};
      count_d  = {CNT_W{1'b0}};
    end
    else
    begin
      if (do_wr)
        wr_ptr_d = wr_ptr_q + {{(ADDR_W-1){1'b0}}, 1'b1};
      if (do_rd)
        rd_ptr_d = rd_ptr_q + {{(ADDR_W-1){1'b0}}, 1'b1};
      case ({do_wr, do_rd})
        2'b10:   count_d = count_q + {{(CNT_W-1){1'b0}}, 1'b1};
        2'b01:   count_d = count_q - {{(CNT_W-1){1'b0}}, 1'b1};
        default: count_d = count_q;
      endcase
    end
  end

  // Next head word: the output always shows the oldest stored word. A word
  // written into the slot the read pointer lands on bypasses the array,
  // which gives fall-through on the first load into an empty buffer.
  // The head is registered so the data pins never glitch as pointers move.
  always @*
  begin
    head_d = head_q;
    if (!flush && count_d != {CNT_W{1'b0}})
    begin
      if (do_wr && rd_ptr_d == wr_ptr_q)
        head_d = din_sync_q;
      else
        head_d = mem[rd_ptr_d];
    end
  end

  // Array write; storage itself needs no reset, stale words are never shown
  // Depth is small enough for flops; a memory macro would not buy much
  always @(posedge pclk)
  begin
    if (do_wr)
      mem[wr_ptr_q] <= din_sync_q;
  end

  // Pointers, count and head register, cleared asynchronously by reset
  // Reset puts no meaningful value on the data outputs, only a harmless zero
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      wr_ptr_q <= {ADDR_W{1'b0}};
      rd_ptr_q <= {ADDR_W{1'b0}};
      count_q  <= {CNT_W{1'b0}};
      head_q   <= {WIDTH{1'b0}};
    end
    else
    begin
      wr_ptr_q <= wr_ptr_d;
      rd_ptr_q <= rd_ptr_d;
      count_q  <= count_d;
      head_q   <= head_d;
    end
  end

  // Flags follow the next count so they move in the same cycle as the data
  // Each flag is a registered compare, so the pins stay free of decode glitches
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      full_n_q  <= 1'b1;
      empty_n_q <= 1'b0;
      near_q    <= 1'b1;
      half_q    <= 1'b0;
    end
    else
    begin
      full_n_q  <= (count_d != `DCF_FULL_CNT);
      empty_n_q <= (count_d != {CNT_W{1'b0}});
      near_q    <= (count_d <= `DCF_NEAR_LO) |
                   (count_d >= `DCF_NEAR_HI);
      half_q    <= (count_d >= `DCF_HALF);
    end
  end

  // Sticky records of ignored strobes; a new event wins over a clear
  // Software reads these to learn that a writer overran or a reader underran
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ldrop_q <= 1'b0;
      udrop_q <= 1'b0;
    end
    else
    begin
      ldrop_q <= drop_ld | (ldrop_q & ~clr_sticky[`DCF_CLR_LDROP_BIT]);
      udrop_q <= drop_ud | (udrop_q & ~clr_sticky[`DCF_CLR_UDROP_BIT]);
    end
  end

  // Register bus slave
  // Zero wait states: read data is latched in the setup cycle
  dcf_apb_regs u_regs (
    .pclk        (pclk),
    .presetn     (presetn),
    .psel        (psel),
    .penable     (penable),
    .pwrite      (pwrite),
    .paddr       (paddr),
    .pwdata      (pwdata),
    .prdata      (prdata),
    .pready      (pready),
    .pslverr     (pslverr),
    .status_word (status_word),
    .head_word   (head_word),
    .drive_en    (drive_en),
    .flush_pulse (flush),
    .clr_sticky  (clr_sticky)
  );

  // Status word gathers the live state for software; unused bits read zero
  always @*
  begin
    status_word                           = 32'h00000000;
    status_word[`DCF_ST_CNT_LSB +: CNT_W] = count_q;
    status_word[`DCF_ST_FULL_N_BIT]       = full_n_q;
    status_word[`DCF_ST_EMPTY_N_BIT]      = empty_n_q;
    status_word[`DCF_ST_NEAR_BIT]         = near_q;
    status_word[`DCF_ST_HALF_BIT]         = half_q;
    status_word[`DCF_ST_LDROP_BIT]        = ldrop_q;
    status_word[`DCF_ST_UDROP_BIT]        = udrop_q;
  end

  // Head word reads zero when empty, since the held value means nothing then
  // Otherwise software sees the same word as the data pins
  assign head_word = empty_n_q ? {{(32-WIDTH){1'b0}}, head_q} : 32'h00000000;

  // The pin driver resolves q_out with q_oe; the core itself never drives z
  // Data outputs are not inverted; the enable gates only the data pins
  assign q_out = head_q;
  assign q_oe  = drive_en;

  // Flag pins ignore the drive enable entirely
  assign full_flag_n       = full_n_q;
  assign empty_flag_n      = empty_n_q;
  assign near_limit_flag   = near_q;
  assign half_level_flag   = half_q;
  assign stored_word_count = count_q;

endmodule // dcf_fifo_top

//--- verification/dcf_fifo_top_assertions.sv
// Concurrent checks on the FIFO count, flags and drive enable
module dcf_fifo_checker #(
  parameter CNT_W = 7
) (
  input wire             pclk,
  input wire             presetn,
  input wire             psel,
  input wire             penable,
  input wire             pwrite,
  input wire [11:0]      paddr,
  input wire [31:0]      pwdata,
  input wire             load_strobe_clk,
  input wire             q_oe,
  input wire             full_flag_n,
  input wire             empty_flag_n,
  input wire             near_limit_flag,
  input wire             half_level_flag,
  input wire [CNT_W-1:0] stored_word_count
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  wire [CNT_W-1:0] cnt;
  assign cnt = stored_word_count;
  // Flags follow the count on the same edge
  full_lvl_a: assert property (full_flag_n == (cnt != 7'h40))
    else $error("full flag wrong");
  empty_lvl_a: assert property (empty_flag_n == (cnt != 7'h00))
    else $error("empty flag wrong");
  near_lvl_a: assert property (near_limit_flag == (cnt <= 7'h08 || cnt >= 7'h38))
    else $error("near flag wrong");
  half_lvl_a: assert property (half_level_flag == (cnt >= 7'h20))
    else $error("half flag wrong");
  cnt_range_a: assert property (cnt <= 7'h40)
    else $error("count above depth");
  empty_hold_a: assert property (cnt == 7'h00 |=> cnt <= 7'h01)
    else $error("count fell below zero");
  // One strobe event moves the count by one; only flush may jump to zero
  cnt_step_a: assert property (cnt != $past(cnt) && cnt != 7'h00 |->
    cnt == $past(cnt) + 1 || cnt == $past(cnt) - 1)
    else $error("count jumped");
  // A quiet load pin cannot grow the count
  ld_quiet_a: assert property ($stable(load_strobe_clk) [*8] |=> cnt <= $past(cnt))
    else $error("count grew without a load edge");
  oe_wr_a: assert property (psel && penable && pwrite && paddr == 12'h000 |=>
    q_oe == $past(pwdata[0]))
    else $error("drive enable not written");
  full_c: cover property (cnt == 7'h40);
  drain_c: cover property ($fell(empty_flag_n));
  oe_off_c: cover property (!q_oe);
endmodule // dcf_fifo_checker

bind dcf_fifo_top dcf_fifo_checker #(.CNT_W(CNT_W)) u_dcf_fifo_checker (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .load_strobe_clk(load_strobe_clk), .q_oe(q_oe),
  .full_flag_n(full_flag_n), .empty_flag_n(empty_flag_n),
  .near_limit_flag(near_limit_flag), .half_level_flag(half_level_flag),
  .stored_word_count(stored_word_count));

//--- verification/dcf_strobe_model.sv
// Writer and reader bus logic strobing the FIFO at a 100 ns period
module dcf_strobe_model (
  input  wire        pclk,
  output logic       load_strobe_clk,
  output logic       unload_strobe_clk,
  output logic [8:0] data_in
);
  timeunit 1ns;
  timeprecision 1ps;
  // One device alone: words may be widened side by side, never chained
  // Strobes idle low so release of reset never looks like an edge
  initial
  begin
    load_strobe_clk = 1'b0;
    unload_strobe_clk = 1'b0;
    data_in = 9'h000;
  end
  // Word held 4 cycles before and 12 after the edge, past the input sync delay
  task automatic load(input logic [8:0] w);
    data_in <= w;
    repeat (4) @(posedge pclk);
    load_strobe_clk <= 1'b1;
    repeat (8) @(posedge pclk);
    load_strobe_clk <= 1'b0;
    repeat (4) @(posedge pclk);
    data_in <= ~w; // Hold over: old word must not linger
    repeat (4) @(posedge pclk);
  endtask
  // Same shape as a load, so both rise together when run side by side
  task automatic unload();
    repeat (4) @(posedge pclk);
    unload_strobe_clk <= 1'b1;
    repeat (8) @(posedge pclk);
    unload_strobe_clk <= 1'b0;
    repeat (8) @(posedge pclk);
  endtask
endmodule // dcf_strobe_model

//--- verification/testbench.sv
// Self-checking bench for the dual-strobe 64x9 FIFO
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic        pclk;
  logic        presetn = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] rd;
  logic        err;
  logic        oe_q;
  wire  [31:0] prdata;
  wire         pready, pslverr, ld, ul, q_oe, full_n, empty_n, near, half;
  wire  [8:0]  data_in, q_out, q_bus;
  wire  [6:0]  cnt;
  int          failures = 0;
  int          n_checks = 0;
  int          cycles = 0;
  int          mq[$];
  assign q_bus = q_oe ? q_out : {9{1'bz}};
  dcf_fifo_top u_dcf_fifo_top (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .load_strobe_clk(ld), .unload_strobe_clk(ul),
    .data_in(data_in), .q_out(q_out), .q_oe(q_oe), .full_flag_n(full_n),
    .empty_flag_n(empty_n), .near_limit_flag(near), .half_level_flag(half),
    .stored_word_count(cnt));
  dcf_strobe_model u_dcf_strobe_model (.pclk(pclk), .load_strobe_clk(ld),
    .unload_strobe_clk(ul), .data_in(data_in));
  // 200 MHz clock
  initial
  begin
    pclk = 1'b0;
    forever #2.5 pclk = ~pclk;
  end
  // Whole run is about 3900 cycles; a hang ends at 20000
  always @(posedge pclk)
  begin
    cycles <= cycles + 1;
    if (cycles == 20000)
    begin
      failures++;
      complete_run();
    end
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      failures++;
      $display("mismatch at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask
  // APB transfer ending with an idle cycle; the next one may start in this same time step
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic check_state();
    int n;
    n = mq.size();
    check(cnt, n);
    check(full_n, n != 64);
    check(empty_n, n != 0);
    check(near, n <= 8 || n >= 56);
    check(half, n >= 32);
    if (n > 0) check(q_bus, oe_q ? mq[0] : {9{1'bz}});
  endtask
  task automatic check_status(input int drops);
    int n;
    int e;
    n = mq.size();
    e = n | (n != 64) << 8 | (n != 0) << 9 | (n <= 8 || n >= 56) << 10;
    e = e | (n >= 32) << 11 | drops << 12;
    apb(1'b0, 12'h004, 32'h0);
    check(rd, e);
    check(err, 1'b0);
  endtask
  task automatic push(input int w);
    u_dcf_strobe_model.load(w[8:0]);
    if (mq.size() < 64) mq.push_back(w);
    check_state();
  endtask
  task automatic pop();
    u_dcf_strobe_model.unload();
    if (mq.size() > 0) void'(mq.pop_front());
    check_state();
  endtask
  task automatic do_reset();
    presetn <= 1'b0;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    mq.delete();
    oe_q = 1'b1;
    @(posedge pclk);
    check_state();
  endtask
  task automatic complete_run();
    $display("checks %0d mismatches %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  // Main sequence
  initial
  begin
    int w;
    int n;
    void'($urandom(32'h9C3E));
    do_reset();
    check_status(0);
    // Fill to the brim, then one load that must be dropped
    repeat (65) push($urandom_range(511));
    check_status(1);
    apb(1'b1, 12'h008, 32'h1);
    apb(1'b0, 12'h010, 32'h0);
    check(err, 1'b1);
    check(rd, 32'h0);
    // Drive enable off releases only the data outputs
    apb(1'b1, 12'h000, 32'h0);
    oe_q = 1'b0;
    check_state();
    check_status(0);
    apb(1'b0, 12'h00C, 32'h0);
    check(rd, mq[0]);
    apb(1'b1, 12'h000, 32'h1);
    oe_q = 1'b1;
    // Drain, then one unload that must be ignored
    repeat (65) pop();
    check_status(2);
    apb(1'b0, 12'h00C, 32'h0);
    check(rd, 32'h0);
    apb(1'b1, 12'h008, 32'h2);
    check_status(0);
    // Random loads, unloads and coinciding pairs, judged on the count before
    repeat (60)
    begin
      w = $urandom_range(511);
      n = $urandom_range(2);
      if (n == 0) push(w);
      else if (n == 1) pop();
      else
      begin
        fork
          u_dcf_strobe_model.load(w[8:0]);
          u_dcf_strobe_model.unload();
        join
        n = mq.size();
        if (n > 0) void'(mq.pop_front());
        if (n < 64) mq.push_back(w);
        check_state();
      end
    end
    // Flush, then a reset in mid-run with words stored
    apb(1'b1, 12'h000, 32'h3);
    repeat (2) @(posedge pclk);
    mq.delete();
    check_state();
    push(9'h1A5);
    push(9'h05A);
    do_reset();
    push(9'h0F3);
    complete_run();
  end
endmodule // testbench
